// >>> mrs_ctrl.sv
// Controller that programs the memory mode registers through MRS commands.
// Assumes software on AXI4-Lite; the memory's command pins are driven directly.
// Contract
// [R1] Device keeps register until rewritten or reset
// [R2] Every MRS carries the complete register value; an MRS to mode register 2 carries mode1_reg
// [R3] MRS only when banks idle and precharged; idle_ok_reg lets an MRS issue while banks_idle is low
// [R4] Wait tMRD before another MRS
// [R5] Only NOP or DES until tMOD
// [R6] Mode 0 bit 3 selects burst ordering
// [R7] Mode 0 bits 1:0 select burst length
// [R8] Burst wraps within aligned column block
// [R9] Read order starts at column low bits
// [R10] Write order ignores low start bits
// [R11] Chopped reads tri-state trailing four beats
// [R12] Chopped bursts start internally like full bursts
// [R13] DLL reset bit self-clears after start
// [R14] Wait 512 clocks after DLL reset before READ
// [R15] Write recovery code 5 to 12 cycles
// [R16] Mode 0 bit 12 sets power-down DLL
// [R17] CAS latency 5, 6, 8, 10
// [R18] DLL enable should be followed by reset
// [R19] DLL follows self refresh entry and exit
// [R20] DLL off restricts ODT and latency
// [R21] Mode 1 bits 5:1 set drive impedance
// [R22] Calibration updates do not disturb operation
// [R23] Mode 1 bit 7 enables write leveling
// [R24] Mode 1 bit 12 disables outputs
// [R25] Mode 1 bits 4:3 set additive latency
// [R26] Bank address picks the target register
// [R27] Device loads register in single cycle
`timescale 1ns/1ns
`default_nettype none
module mrs_ctrl #(
    parameter int DLLK_CYCLES = mrs_ctrl_pkg::TDLLK_CK
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Bank idle indication from the scheduler, asynchronous
    input  wire logic        banks_idle,
    // Memory command pins
    output logic             mem_cs_n,
    output logic             mem_ras_n,
    output logic             mem_cas_n,
    output logic             mem_we_n,
    output logic [2:0]       mem_ba,
    output logic [15:0]      mem_addr,
    // Gates for the scheduler
    output logic             cmd_allowed,
    output logic             read_allowed
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_ISSUE = 4'b0100,
        ST_HOLD  = 4'b1000
    } mrs_state_e;

    mrs_state_e   state_reg;
    mrs_state_e   state_next;
    logic [15:0]  mode0_reg;
    logic [15:0]  mode1_reg;
    logic [15:0]  shadow0_reg;
    logic [15:0]  shadow1_reg;
    logic [2:0]   sel_reg;
    logic         pend_reg;
    logic         idle_ok_reg;
    logic         err_reg;
    logic         dll_pend_reg;
    logic [2:0]   idle_sync_reg;
    logic         idle_stable_reg;
    logic         aw_done_reg;
    logic         w_done_reg;
    logic [7:0]   awaddr_reg;
    logic [31:0]  wdata_reg;
    logic [3:0]   wstrb_reg;
    logic         bvalid_reg;
    logic         rvalid_reg;
    logic [31:0]  rdata_reg;
    logic [3:0]   cmd_reg;
    logic [2:0]   ba_reg;
    logic [15:0]  addr_reg;
    logic         mrd_done;
    logic         mod_done;
    logic         dllk_done;
    logic         issue;
    logic         wr_fire;
    logic         rd_fire;
    logic         go_wr;
    logic [15:0]  issue_val;
    logic [15:0]  dll_rst_mask;
    logic         dll_rst_sent;
    logic         dll_en_sent;
    logic         sel_ok;

    // Merge byte lanes of a write into a 16-bit register value
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Three-stage pin synchroniser; stages two and three must agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_sync_reg   <= 3'h0;
            idle_stable_reg <= 1'b0;
        end else begin
            idle_sync_reg <= {idle_sync_reg[1:0], banks_idle};
            if (idle_sync_reg[1] == idle_sync_reg[2]) begin
                idle_stable_reg <= idle_sync_reg[2];
            end
        end
    end

    // AXI4-Lite write channel: address and data in either order
    assign s_axi_awready = !aw_done_reg && !bvalid_reg;
    assign s_axi_wready  = !w_done_reg && !bvalid_reg;
    assign wr_fire       = (aw_done_reg || (s_axi_awvalid && s_axi_awready))
                         && (w_done_reg || (s_axi_wvalid && s_axi_wready));
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_done_reg <= 1'b0;
            w_done_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_done_reg <= wr_fire ? 1'b0 : (aw_done_reg || (s_axi_awvalid && s_axi_awready));
            w_done_reg  <= wr_fire ? 1'b0 : (w_done_reg || (s_axi_wvalid && s_axi_wready));
            bvalid_reg  <= wr_fire || (bvalid_reg && !s_axi_bready);
        end
    end

    // Effective write payload, either just taken or held
    logic [7:0]  eff_addr;
    logic [31:0] eff_data;
    logic [3:0]  eff_strb;
    assign eff_addr = aw_done_reg ? awaddr_reg : s_axi_awaddr;
    assign eff_data = w_done_reg ? wdata_reg : s_axi_wdata;
    assign eff_strb = w_done_reg ? wstrb_reg : s_axi_wstrb;
    assign go_wr    = wr_fire && eff_addr == mrs_ctrl_pkg::OFF_CTRL && eff_strb[0]
                    && eff_data[mrs_ctrl_pkg::CTRL_GO_BIT];

    // Only mode registers 0, 1 and 2 targets are accepted
    assign sel_ok = eff_data[mrs_ctrl_pkg::CTRL_SEL_HI:mrs_ctrl_pkg::CTRL_SEL_LO] <= mrs_ctrl_pkg::BA_MODE2;

    // Software-side registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode0_reg   <= mrs_ctrl_pkg::MODE0_RST;
            mode1_reg   <= mrs_ctrl_pkg::MODE1_RST;
            sel_reg     <= 3'h0;
            idle_ok_reg <= 1'b0;
            pend_reg    <= 1'b0;
            err_reg     <= 1'b0;
        end else begin
            if (wr_fire && eff_addr == mrs_ctrl_pkg::OFF_MODE0) begin
                mode0_reg <= merge16(mode0_reg, eff_data, eff_strb);
            end
            if (wr_fire && eff_addr == mrs_ctrl_pkg::OFF_MODE1) begin
                mode1_reg <= merge16(mode1_reg, eff_data, eff_strb);
            end
            if (wr_fire && eff_addr == mrs_ctrl_pkg::OFF_CTRL && eff_strb[0]) begin
                idle_ok_reg <= eff_data[mrs_ctrl_pkg::CTRL_IDLE_OK_BIT];
            end
            // A new request in the issue cycle is refused and flagged, since pend_reg is still set
            if (go_wr && sel_ok && !pend_reg) begin
                sel_reg  <= eff_data[mrs_ctrl_pkg::CTRL_SEL_HI:mrs_ctrl_pkg::CTRL_SEL_LO];
                pend_reg <= 1'b1;
            end else if (issue) begin
                pend_reg <= 1'b0;
            end
            // Error sets win over a status read clear
            if (go_wr && (!sel_ok || pend_reg)) begin
                err_reg <= 1'b1;
            end else if (rd_fire && s_axi_araddr == mrs_ctrl_pkg::OFF_STATUS) begin
                err_reg <= 1'b0;
            end
        end
    end

    // Spacing timers
    mrs_spacing_timer #(.W(10)) u_mrd (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (issue),
        .count   (10'(mrs_ctrl_pkg::TMRD_CK - 1)),
        .done    (mrd_done)
    );
    mrs_spacing_timer #(.W(10)) u_mod (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (issue),
        .count   (10'(mrs_ctrl_pkg::TMOD_CK - 1)),
        .done    (mod_done)
    );
    // Full count: no hold state follows this timer, so a read launched at once is still late enough
    mrs_spacing_timer #(.W(10)) u_dllk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (dll_rst_sent),
        .count   (10'(DLLK_CYCLES)),
        .done    (dllk_done)
    );

    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  state_next = pend_reg ? ST_WAIT : ST_IDLE;
            ST_WAIT:  state_next = (mrd_done && mod_done && (idle_stable_reg || idle_ok_reg)) ? ST_ISSUE : ST_WAIT; // [R3] [R4]
            ST_ISSUE: state_next = ST_HOLD;
            ST_HOLD:  state_next = mod_done ? ST_IDLE : ST_HOLD; // [R5]
            default:  state_next = ST_IDLE;
        endcase
    end
    assign issue = state_reg == ST_ISSUE;

    // Whole register value goes out each time, mode1_reg for a mode 2 target; mode 0 forces DLL reset after a DLL enable
    assign dll_rst_mask = 16'h0001 << mrs_ctrl_pkg::M0_DLLRST_BIT;
    assign issue_val = (sel_reg == mrs_ctrl_pkg::BA_MODE0) // [R7] [R15] [R16]
                     ? (mode0_reg | (dll_pend_reg ? dll_rst_mask : 16'h0000)) : mode1_reg; // [R2] [R18]
    assign dll_rst_sent = issue && sel_reg == mrs_ctrl_pkg::BA_MODE0 && issue_val[mrs_ctrl_pkg::M0_DLLRST_BIT]; // [R13]
    assign dll_en_sent  = issue && sel_reg == mrs_ctrl_pkg::BA_MODE1 && mode1_reg[mrs_ctrl_pkg::M1_DLLEN_BIT]; // [R18]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= ST_IDLE;
            cmd_reg      <= mrs_ctrl_pkg::CMD_NOP;
            ba_reg       <= 3'h0;
            addr_reg     <= 16'h0000;
            shadow0_reg  <= mrs_ctrl_pkg::MODE0_RST;
            shadow1_reg  <= mrs_ctrl_pkg::MODE1_RST;
            dll_pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg   <= issue ? mrs_ctrl_pkg::CMD_MRS : mrs_ctrl_pkg::CMD_NOP; // [R5]
            if (issue) begin
                ba_reg   <= sel_reg; // [R26]
                addr_reg <= issue_val; // [R2]
            end
            // Shadow mirrors what the device holds; DLL reset bit is not retained
            if (issue && sel_reg == mrs_ctrl_pkg::BA_MODE0) begin
                shadow0_reg <= issue_val & ~dll_rst_mask; // [R1] [R13]
            end
            if (issue && sel_reg == mrs_ctrl_pkg::BA_MODE1) begin
                shadow1_reg <= issue_val; // [R1]
            end
            if (dll_en_sent) begin
                dll_pend_reg <= 1'b1; // [R18]
            end else if (dll_rst_sent) begin
                dll_pend_reg <= 1'b0;
            end
        end
    end

    assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = cmd_reg;
    assign mem_ba       = ba_reg;
    assign mem_addr     = addr_reg;
    assign cmd_allowed  = mod_done && state_reg != ST_HOLD && state_reg != ST_ISSUE; // [R5]
    assign read_allowed = cmd_allowed && dllk_done; // [R14]

    // AXI4-Lite read channel
    assign s_axi_arready = !rvalid_reg;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = 2'h0;

    logic [31:0] rd_mux;
    assign rd_mux =
        (s_axi_araddr == mrs_ctrl_pkg::OFF_CTRL)    ? {27'h0, idle_ok_reg, sel_reg, pend_reg} :
        (s_axi_araddr == mrs_ctrl_pkg::OFF_MODE0)   ? {16'h0, mode0_reg} :
        (s_axi_araddr == mrs_ctrl_pkg::OFF_MODE1)   ? {16'h0, mode1_reg} :
        (s_axi_araddr == mrs_ctrl_pkg::OFF_STATUS)  ? {27'h0, err_reg, dllk_done, mod_done, mrd_done,
                                                      state_reg != ST_IDLE || pend_reg} :
        (s_axi_araddr == mrs_ctrl_pkg::OFF_SHADOW0) ? {16'h0, shadow0_reg} :
        (s_axi_araddr == mrs_ctrl_pkg::OFF_SHADOW1) ? {16'h0, shadow1_reg} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            if (rd_fire) begin
                rdata_reg <= rd_mux;
            end
            rvalid_reg <= rd_fire || (rvalid_reg && !s_axi_rready);
        end
    end

    // Assertions
    int unsigned since_mrs;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_mrs <= 1000;
        end else if (cmd_reg == mrs_ctrl_pkg::CMD_MRS) begin
            since_mrs <= 1;
        end else if (since_mrs < 1000) begin
            since_mrs <= since_mrs + 1;
        end
    end

    sequence s_mrs_out;
        cmd_reg == mrs_ctrl_pkg::CMD_MRS;
    endsequence

    a_mrd_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        s_mrs_out |-> since_mrs >= mrs_ctrl_pkg::TMRD_CK)
        else $error("MRS issued before tMRD");
    a_mod_nop_only: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
        s_mrs_out |=> (cmd_reg == mrs_ctrl_pkg::CMD_NOP) [*8])
        else $error("Non-NOP command inside tMOD");
    a_mod_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
        cmd_allowed |-> since_mrs >= mrs_ctrl_pkg::TMOD_CK)
        else $error("Commands allowed before tMOD");
    a_dll_read_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        dll_rst_sent |=> !read_allowed [*8])
        else $error("Read allowed soon after DLL reset");
    a_full_value: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        issue |=> mem_addr == $past(issue_val) && mem_ba == $past(sel_reg))
        else $error("MRS payload differs from register");
    a_idle_needed: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        issue |-> $past(idle_stable_reg || idle_ok_reg))
        else $error("MRS issued while banks busy");
    a_dll_self_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
        dll_rst_sent |=> !shadow0_reg[mrs_ctrl_pkg::M0_DLLRST_BIT])
        else $error("DLL reset bit retained");
    a_dll_follow: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
        (issue && sel_reg == mrs_ctrl_pkg::BA_MODE0 && dll_pend_reg) |-> issue_val[mrs_ctrl_pkg::M0_DLLRST_BIT])
        else $error("DLL enable not followed by reset");
endmodule
`default_nettype wire

// >>> mrs_ctrl_pkg.sv
// Constants for the mode register set controller.
// Assumes a DDR3-style command bus on the far side and AXI4-Lite toward software.
package mrs_ctrl_pkg;
    // AXI4-Lite register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_MODE0   = 8'h04;
    localparam logic [7:0] OFF_MODE1   = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;
    localparam logic [7:0] OFF_SHADOW0 = 8'h10;
    localparam logic [7:0] OFF_SHADOW1 = 8'h14;
    // Control register bit positions
    localparam int CTRL_GO_BIT       = 0;
    localparam int CTRL_SEL_LO       = 1;
    localparam int CTRL_SEL_HI       = 3;
    localparam int CTRL_IDLE_OK_BIT  = 4;
    localparam int CTRL_FORCE_DLL    = 5;
    // Status bit positions
    localparam int ST_BUSY_BIT       = 0;
    localparam int ST_MRD_BIT        = 1;
    localparam int ST_MOD_BIT        = 2;
    localparam int ST_DLLK_BIT       = 3;
    localparam int ST_ERR_BIT        = 4;
    // Mode register 0 field positions
    localparam int M0_BL_LO          = 0;
    localparam int M0_BL_HI          = 1;
    localparam int M0_BT_BIT         = 3;
    localparam int M0_CL_LO          = 4;
    localparam int M0_CL_HI          = 6;
    localparam int M0_DLLRST_BIT     = 8;
    localparam int M0_WR_LO          = 9;
    localparam int M0_WR_HI          = 11;
    localparam int M0_PPD_BIT        = 12;
    // Mode register 1 field positions
    localparam int M1_DLLEN_BIT      = 0;
    localparam int M1_WL_BIT         = 7;
    localparam int M1_QOFF_BIT       = 12;
    // Bank address selecting each mode register
    localparam logic [2:0] BA_MODE0  = 3'h0;
    localparam logic [2:0] BA_MODE1  = 3'h1;
    localparam logic [2:0] BA_MODE2  = 3'h2;
    // Reset values
    localparam logic [15:0] MODE0_RST = 16'h0000;
    localparam logic [15:0] MODE1_RST = 16'h0000;
    // Command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS   = 4'h0;
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_DES   = 4'h8;
    // Timing counts in clocks
    localparam int TMRD_CK           = 4;
    localparam int TMOD_CK           = 12;
    localparam int TDLLK_CK          = 512;
    // Pin synchroniser depth
    localparam int SYNC_STAGES       = 3;
endpackage

// >>> mrs_spacing_timer.sv
// Down-counter used for command spacing after a mode register set.
// Assumes load and count are from logic on aclk.
`timescale 1ns/1ns
`default_nettype none
module mrs_spacing_timer #(
    parameter int W = 10
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // Status
    output logic              done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    assign cnt_next = load ? count : (cnt_reg != '0 ? cnt_reg - W'(1) : cnt_reg);
    assign done     = (cnt_reg == '0) && !load;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// >>> mode_reg_model.sv
// Memory-side model: decodes commands on the pins and holds the mode registers.
// Assumes the controller drives its command pins from aclk.
`timescale 1ns/1ns
`default_nettype none
module mode_reg_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Command pins
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [2:0]  ba,
    input  wire logic [15:0] addr,
    // Observed state
    output logic [15:0]      mr0,
    output logic [15:0]      mr1,
    output logic [2:0]       last_ba,
    output logic             dll_rst,
    output int               n_mrs,
    output int               n_bad
);
    logic is_mrs;
    logic is_idle;
    int   since;
    assign is_mrs  = {cs_n, ras_n, cas_n, we_n} == mrs_ctrl_pkg::CMD_MRS;
    assign is_idle = cs_n || ({cs_n, ras_n, cas_n, we_n} == mrs_ctrl_pkg::CMD_NOP);
    // Field decodes the array would act on; no data path is modelled
    wire logic [1:0] burst_len  = mr0[1:0];
    wire logic       interleave = mr0[3];
    wire logic [2:0] cas_code   = mr0[6:4];
    wire logic [2:0] wr_code    = mr0[11:9];
    wire logic       ppd_dll_on = mr0[12];
    wire logic       dll_on     = mr1[0];
    wire logic [4:0] drive_imp  = mr1[5:1];
    wire logic [1:0] add_lat    = mr1[4:3];
    wire logic       wlevel_on  = mr1[7];
    wire logic       out_off    = mr1[12];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mr0     <= mrs_ctrl_pkg::MODE0_RST;
            mr1     <= mrs_ctrl_pkg::MODE1_RST;
            last_ba <= 3'h0;
            dll_rst <= 1'b0;
            n_mrs   <= 0;
            n_bad   <= 0;
            since   <= 1000;
        end else begin
            since <= (since < 1000) ? since + 1 : since;
            if (is_mrs) begin
                since   <= 1;
                n_mrs   <= n_mrs + 1;
                last_ba <= ba;
                if (n_mrs > 0 && since < mrs_ctrl_pkg::TMRD_CK) n_bad <= n_bad + 1;
                if (ba == mrs_ctrl_pkg::BA_MODE0) begin
                    mr0     <= addr & 16'hfeff;
                    dll_rst <= addr[8];
                end
                if (ba == mrs_ctrl_pkg::BA_MODE1) mr1 <= addr;
            end else if (!is_idle && since < mrs_ctrl_pkg::TMOD_CK) begin
                n_bad <= n_bad + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the mode register set controller.
// Assumes the controller's AXI4-Lite timing and a short DLL lock count.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int DLLK = 16;
    logic aclk, aresetn, banks_idle;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, cmd_allowed, read_allowed, dll_rst;
    logic [2:0] mem_ba, last_ba;
    logic [15:0] mem_addr, mr0, mr1;
    int n_mrs, n_bad, n_mismatch, num_checks, cycles, lo;

    mrs_ctrl #(.DLLK_CYCLES(DLLK)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .banks_idle(banks_idle),
        .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
        .mem_ba(mem_ba), .mem_addr(mem_addr), .cmd_allowed(cmd_allowed), .read_allowed(read_allowed));
    mode_reg_model mem (.aclk(aclk), .aresetn(aresetn), .cs_n(mem_cs_n), .ras_n(mem_ras_n),
        .cas_n(mem_cas_n), .we_n(mem_we_n), .ba(mem_ba), .addr(mem_addr), .mr0(mr0), .mr1(mr1),
        .last_ba(last_ba), .dll_rst(dll_rst), .n_mrs(n_mrs), .n_bad(n_bad));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // Ready is sampled at the falling edge so the handshake edge is known before it comes
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_ok) begin
            @(negedge aclk);
            b_ok = s_axi_bvalid;
            aw_ok = aw_ok || (s_axi_awvalid && s_axi_awready);
            w_ok = w_ok || (s_axi_wvalid && s_axi_wready);
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        logic ar_ok, r_ok;
        ar_ok = 1'b0;
        r_ok = 1'b0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!r_ok) begin
            @(negedge aclk);
            r_ok = s_axi_rvalid;
            d = s_axi_rdata;
            ar_ok = ar_ok || (s_axi_arvalid && s_axi_arready);
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_mrs(input int prev);
        int t;
        t = 0;
        while (n_mrs == prev && t < 80) begin
            @(negedge aclk);
            t++;
        end
        check("mrs count", prev + 1, n_mrs);
    endtask
    task automatic count_low(input logic which, input int lim);
        lo = 0;
        while (((which ? read_allowed : cmd_allowed) !== 1'b1) && lo < lim) begin
            @(negedge aclk);
            lo++;
        end
    endtask
    task automatic reset_state;
        check("cmd allowed", 1, cmd_allowed);
        check("read allowed", 1, read_allowed);
        axi_rd(mrs_ctrl_pkg::OFF_MODE0, rd);
        check("mode0 reset", 32'(mrs_ctrl_pkg::MODE0_RST), rd);
        axi_wr(8'h3c, 32'h0000_ffff);
        check("write response", 0, 32'(s_axi_bresp));
        axi_rd(8'h3c, rd);
        check("unmapped read", 32'h0, rd);
        check("read response", 0, 32'(s_axi_rresp));
        check("no command", 0, n_mrs);
    endtask
    task automatic load_mode1;
        axi_wr(mrs_ctrl_pkg::OFF_MODE1, 32'h0000_1081);
        axi_wr(mrs_ctrl_pkg::OFF_CTRL, 32'h0000_0003);
        wait_mrs(0);
        check("target bank", 32'(mrs_ctrl_pkg::BA_MODE1), 32'(last_ba));
        check("mode1 loaded", 32'h1081, 32'(mr1));
        count_low(1'b0, 60);
        check("tmod wait", 1, 32'(lo == mrs_ctrl_pkg::TMOD_CK - 1));
        axi_rd(mrs_ctrl_pkg::OFF_SHADOW1, rd);
        check("shadow1", 32'h1081, rd);
    endtask
    task automatic load_mode0;
        axi_wr(mrs_ctrl_pkg::OFF_MODE0, 32'h0000_0a58);
        axi_wr(mrs_ctrl_pkg::OFF_CTRL, 32'h0000_0001);
        wait_mrs(1);
        check("mode0 target", 32'(mrs_ctrl_pkg::BA_MODE0), 32'(last_ba));
        check("mode0 loaded", 32'h0a58, 32'(mr0));
        check("dll reset sent", 1, 32'(dll_rst));
        check("mode1 kept", 32'h1081, 32'(mr1));
        count_low(1'b1, 200);
        check("dll lock wait", 1, 32'(lo == DLLK - 1));
        axi_rd(mrs_ctrl_pkg::OFF_SHADOW0, rd);
        check("shadow0 bit8 clear", 32'h0a58, rd);
    endtask
    task automatic busy_banks;
        axi_wr(mrs_ctrl_pkg::OFF_CTRL, 32'h0000_000b);
        axi_rd(mrs_ctrl_pkg::OFF_STATUS, rd);
        check("bad select flagged", 1, 32'(rd[mrs_ctrl_pkg::ST_ERR_BIT]));
        axi_rd(mrs_ctrl_pkg::OFF_STATUS, rd);
        check("flag cleared", 0, 32'(rd[mrs_ctrl_pkg::ST_ERR_BIT]));
        banks_idle <= 1'b0;
        // Let the busy level through the synchroniser before the request
        repeat (4) @(posedge aclk);
        axi_wr(mrs_ctrl_pkg::OFF_CTRL, 32'h0000_0003);
        repeat (30) @(posedge aclk);
        check("held while busy", 2, n_mrs);
        axi_wr(mrs_ctrl_pkg::OFF_CTRL, 32'h0000_0003);
        axi_rd(mrs_ctrl_pkg::OFF_STATUS, rd);
        check("second go refused", 32'h11, rd & 32'h11);
        banks_idle <= 1'b1;
        wait_mrs(2);
        check("spacing kept", 0, n_bad);
        @(posedge aclk);
        banks_idle <= 1'b0;
        axi_wr(mrs_ctrl_pkg::OFF_CTRL, 32'h0000_0015);
        wait_mrs(3);
        check("override target", 32'(mrs_ctrl_pkg::BA_MODE2), 32'(last_ba));
        check("override spacing", 0, n_bad);
    endtask
    initial begin
        {aresetn, banks_idle, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b01000;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        n_mismatch = 0;
        num_checks = 0;
        cycles = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        reset_state();
        load_mode1();
        load_mode0();
        busy_banks();
        complete_run();
    end
endmodule
`default_nettype wire
